// ==== hdl/rgb_timing_map.vh ====
// register offsets, field positions, reset values and encodings of the rgb panel timing generator
// assumes inclusion by the generator source and the testbench top; holds definitions, no logic
`ifndef RGB_TIMING_MAP_VH
`define RGB_TIMING_MAP_VH

// register byte offsets, one aligned 32-bit word each
`define OFF_CTRL        8'h00
`define OFF_HSIZE       8'h04
`define OFF_HPORCH      8'h08
`define OFF_VSIZE       8'h0C
`define OFF_VPORCH      8'h10
`define OFF_STATUS      8'h14

// control word fields
`define CTRL_EN_BIT     0
`define CTRL_HPOL_BIT   1
`define CTRL_VPOL_BIT   2
`define CTRL_CPOL_BIT   3
`define CTRL_DEPTH_LO   4
`define CTRL_DEPTH_HI   5
`define CTRL_MASK       32'h0000003F

// size and porch words: low field [11:0], high field [27:16]
`define FLD_LO_LSB      0
`define FLD_LO_MSB      11
`define FLD_HI_LSB      16
`define FLD_HI_MSB      27
`define FLD_MASK        32'h0FFF0FFF

// status word fields
`define STAT_LINE_MSB   11
`define STAT_VALID_BIT  16
`define STAT_VSYNC_BIT  17
`define STAT_HSYNC_BIT  18
`define STAT_FRM_LSB    24
`define STAT_FRM_MSB    31

// reset values (640x480, 800 clocks by 525 lines)
`define RST_CTRL        32'h00000000
`define RST_HSIZE       32'h00010280
`define RST_HPORCH      32'h0072002E
`define RST_VSIZE       32'h000101E0
`define RST_VPORCH      32'h000B0022

// interface depth codes
`define DEPTH_24        2'h0
`define DEPTH_18        2'h1
`define DEPTH_16        2'h2

// axi responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== hdl/rgb_timing_gen.v ====
// rgb panel sync timing generator with axi4-lite register slave
// assumes aclk well above the pixel clock; pixel clock arrives asynchronously, pixel data on aclk
`default_nettype none
`include "rgb_timing_map.vh"

////////////////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - back porch counted in pixel clocks from line sync start to first pixel.
// - programmable front porch between last pixel and next line sync.
// - frame back porch counted in lines from frame sync start to first line.
// - programmable frame front porch in lines after last active line.
// - frame sync lasts a programmable number of whole lines.
// - line sync lasts a programmable number of pixel clocks.
// - line length is active pixels plus back porch plus front porch.
// - frame length is active lines plus back porch plus front porch.
// - separate sync polarities; 0 active low, 1 active high.
// - frame starts with frame sync together with first line sync.
// - pixel valid stays low during frame back porch lines.
// - pixel valid asserted once per active line inside that line.
// - pixel valid stays low during frame front porch lines.
// - frame sync width is counted inside the frame back porch.
// - line is sync, back porch without valid, then active area.
// - pixel valid lasts exactly the active pixel count per line.
// - frame sequence kept even when the panel ignores sync signals.
// - 34-line back porch, 11-line front porch, 480 lines gives 525.
// - blank-only panel: 20 blank lines split 10 and 10, one-line sync.
// - unused frame sync: active low, one line, blank split evenly.
// - clock polarity selects launch edge; high launches on falling edge.
// - deeper pixels lose least significant bits per colour, no dithering.
module rgb_timing_gen (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        pixel_clock_in,
  input  wire [23:0] pixel_in,
  output reg         pixel_take,
  output reg         pixel_clock_out,
  output reg         line_sync,
  output reg         frame_sync,
  output reg         pixel_valid,
  output reg  [23:0] rgb_out,
  output reg         frame_start
);

////////////////////////////////////////////////////////////////////////////////////////////////////
// register file

reg  [31:0] ctrl_reg;
reg  [31:0] hsize_reg;
reg  [31:0] hporch_reg;
reg  [31:0] vsize_reg;
reg  [31:0] vporch_reg;
reg  [7:0]  frame_count_reg;

reg         aw_held_reg;
reg  [7:0]  aw_addr_reg;
reg         w_held_reg;
reg  [31:0] w_data_reg;
reg  [3:0]  w_strb_reg;

wire        aw_take = s_axi_awvalid & s_axi_awready;
wire        w_take  = s_axi_wvalid & s_axi_wready;
wire        do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
wire        ar_take = s_axi_arvalid & s_axi_arready;

function [31:0] merge;
  input [31:0] old_val;
  input [31:0] new_val;
  input [3:0]  strb;
  input [31:0] mask;
  integer      i;
  begin
    merge = old_val;
    for (i = 0; i < 4; i = i + 1) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    merge = merge & mask;
  end
endfunction

function mapped;
  input [7:0] addr;
  begin
    mapped = (addr == `OFF_CTRL) || (addr == `OFF_HSIZE) || (addr == `OFF_HPORCH) ||
             (addr == `OFF_VSIZE) || (addr == `OFF_VPORCH) || (addr == `OFF_STATUS);
  end
endfunction

// write channel: address and data taken in either order, response after both
always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_awready <= 1'b1;
    s_axi_wready  <= 1'b1;
    s_axi_bvalid  <= 1'b0;
    s_axi_bresp   <= `RESP_OKAY;
    aw_held_reg   <= 1'b0;
    aw_addr_reg   <= 8'h00;
    w_held_reg    <= 1'b0;
    w_data_reg    <= 32'h00000000;
    w_strb_reg    <= 4'h0;
    ctrl_reg      <= `RST_CTRL;
    hsize_reg     <= `RST_HSIZE;
    hporch_reg    <= `RST_HPORCH;
    vsize_reg     <= `RST_VSIZE;
    vporch_reg    <= `RST_VPORCH;
  end else begin
    if (aw_take) begin
      aw_held_reg   <= 1'b1;
      aw_addr_reg   <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    if (w_take) begin
      w_held_reg   <= 1'b1;
      w_data_reg   <= s_axi_wdata;
      w_strb_reg   <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      case (aw_addr_reg)
        `OFF_CTRL:   ctrl_reg   <= merge(ctrl_reg, w_data_reg, w_strb_reg, `CTRL_MASK);
        `OFF_HSIZE:  hsize_reg  <= merge(hsize_reg, w_data_reg, w_strb_reg, `FLD_MASK);
        `OFF_HPORCH: hporch_reg <= merge(hporch_reg, w_data_reg, w_strb_reg, `FLD_MASK);
        `OFF_VSIZE:  vsize_reg  <= merge(vsize_reg, w_data_reg, w_strb_reg, `FLD_MASK);
        `OFF_VPORCH: vporch_reg <= merge(vporch_reg, w_data_reg, w_strb_reg, `FLD_MASK);
        default: begin
        end
      endcase
    end
    if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid  <= 1'b0;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////////////////////////
// pixel clock synchroniser and edge finder

reg         pclk_meta_reg;
reg         pclk_sync_reg;
reg         pclk_prev_reg;
reg         cpol_reg;

wire        pclk_rise = pclk_sync_reg & ~pclk_prev_reg;
wire        pclk_fall = ~pclk_sync_reg & pclk_prev_reg;
wire        tick = cpol_reg ? pclk_fall : pclk_rise;

always @(posedge aclk) begin
  if (!aresetn) begin
    pclk_meta_reg   <= 1'b0;
    pclk_sync_reg   <= 1'b0;
    pclk_prev_reg   <= 1'b0;
    pixel_clock_out <= 1'b0;
  end else begin
    pclk_meta_reg   <= pixel_clock_in;
    pclk_sync_reg   <= pclk_meta_reg;
    pclk_prev_reg   <= pclk_sync_reg;
    pixel_clock_out <= pclk_prev_reg;
  end
end

////////////////////////////////////////////////////////////////////////////////////////////////////
// frame shadow settings

reg         en_reg;
reg         hpol_reg;
reg         vpol_reg;
reg  [1:0]  depth_reg;
reg  [11:0] active_pixels_per_line;
reg  [11:0] line_sync_width;
reg  [11:0] line_back_porch;
reg  [11:0] line_front_porch;
reg  [11:0] active_lines_per_frame;
reg  [11:0] frame_sync_width;
reg  [11:0] frame_back_porch;
reg  [11:0] frame_front_porch;

reg  [11:0] h_cnt_reg;
reg  [11:0] v_cnt_reg;

wire [12:0] line_total_clocks = {1'b0, active_pixels_per_line} + {1'b0, line_back_porch} +
                                {1'b0, line_front_porch};
wire [12:0] frame_total_lines = {1'b0, active_lines_per_frame} + {1'b0, frame_back_porch} +
                                {1'b0, frame_front_porch};
wire        line_end  = ({1'b0, h_cnt_reg} + 13'h0001) >= line_total_clocks;
wire        frame_end = ({1'b0, v_cnt_reg} + 13'h0001) >= frame_total_lines;
wire        boundary  = ~en_reg | (tick & line_end & frame_end);

// settings copied only while stopped or at the last clock of a frame
always @(posedge aclk) begin
  if (!aresetn) begin
    en_reg                 <= 1'b0;
    hpol_reg               <= 1'b0;
    vpol_reg               <= 1'b0;
    cpol_reg               <= 1'b0;
    depth_reg              <= `DEPTH_24;
    active_pixels_per_line <= 12'h000;
    line_sync_width        <= 12'h000;
    line_back_porch        <= 12'h000;
    line_front_porch       <= 12'h000;
    active_lines_per_frame <= 12'h000;
    frame_sync_width       <= 12'h000;
    frame_back_porch       <= 12'h000;
    frame_front_porch      <= 12'h000;
  end else if (boundary) begin
    en_reg                 <= ctrl_reg[`CTRL_EN_BIT];
    hpol_reg               <= ctrl_reg[`CTRL_HPOL_BIT];
    vpol_reg               <= ctrl_reg[`CTRL_VPOL_BIT];
    cpol_reg               <= ctrl_reg[`CTRL_CPOL_BIT];
    depth_reg              <= ctrl_reg[`CTRL_DEPTH_HI:`CTRL_DEPTH_LO];
    active_pixels_per_line <= hsize_reg[`FLD_LO_MSB:`FLD_LO_LSB];
    line_sync_width        <= hsize_reg[`FLD_HI_MSB:`FLD_HI_LSB];
    line_back_porch        <= hporch_reg[`FLD_LO_MSB:`FLD_LO_LSB];
    line_front_porch       <= hporch_reg[`FLD_HI_MSB:`FLD_HI_LSB];
    active_lines_per_frame <= vsize_reg[`FLD_LO_MSB:`FLD_LO_LSB];
    frame_sync_width       <= vsize_reg[`FLD_HI_MSB:`FLD_HI_LSB];
    frame_back_porch       <= vporch_reg[`FLD_LO_MSB:`FLD_LO_LSB];
    frame_front_porch      <= vporch_reg[`FLD_HI_MSB:`FLD_HI_LSB];
  end
end

////////////////////////////////////////////////////////////////////////////////////////////////////
// line and frame counters

always @(posedge aclk) begin
  if (!aresetn || !en_reg) begin
    h_cnt_reg <= 12'h000;
    v_cnt_reg <= 12'h000;
  end else if (tick) begin
    if (line_end) begin
      h_cnt_reg <= 12'h000;
      if (frame_end) begin
        v_cnt_reg <= 12'h000;
      end else begin
        v_cnt_reg <= v_cnt_reg + 12'h001;
      end
    end else begin
      h_cnt_reg <= h_cnt_reg + 12'h001;
    end
  end
end

// horizontal window: sync from clock 0, back porch includes sync, active after it
wire [12:0] h_act_end = {1'b0, line_back_porch} + {1'b0, active_pixels_per_line};
wire        h_sync_on = h_cnt_reg < line_sync_width;
wire        h_active  = (h_cnt_reg >= line_back_porch) &&
                        ({1'b0, h_cnt_reg} < h_act_end);

// vertical window: sync counted in whole lines, inside the back porch
wire [12:0] v_act_end = {1'b0, frame_back_porch} + {1'b0, active_lines_per_frame};
wire        v_sync_on = v_cnt_reg < frame_sync_width;
wire        v_active  = (v_cnt_reg >= frame_back_porch) &&
                        ({1'b0, v_cnt_reg} < v_act_end);

wire        valid_now = en_reg & h_active & v_active;

////////////////////////////////////////////////////////////////////////////////////////////////////
// panel outputs

reg         tick_d_reg;
reg  [23:0] reduced;

// low bits of each colour dropped, survivors packed from bit 0
always @* begin
  case (depth_reg)
    `DEPTH_18: reduced = {6'h00, pixel_in[23:18], pixel_in[15:10], pixel_in[7:2]};
    `DEPTH_16: reduced = {8'h00, pixel_in[23:19], pixel_in[15:10], pixel_in[7:3]};
    default:   reduced = pixel_in;
  endcase
end

always @(posedge aclk) begin
  if (!aresetn) begin
    tick_d_reg  <= 1'b0;
    line_sync   <= 1'b1;
    frame_sync  <= 1'b1;
    pixel_valid <= 1'b0;
    pixel_take  <= 1'b0;
    frame_start <= 1'b0;
    rgb_out     <= 24'h000000;
  end else begin
    tick_d_reg  <= tick & en_reg;
    line_sync   <= ~((en_reg & h_sync_on) ^ hpol_reg);
    frame_sync  <= ~((en_reg & v_sync_on) ^ vpol_reg);
    pixel_valid <= valid_now;
    pixel_take  <= tick_d_reg & valid_now;
    frame_start <= tick_d_reg & (h_cnt_reg == 12'h000) & (v_cnt_reg == 12'h000);
    if (tick_d_reg && valid_now) begin
      rgb_out <= reduced;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////////////////////////
// frame counter and read channel

always @(posedge aclk) begin
  if (!aresetn) begin
    frame_count_reg <= 8'h00;
  end else if (tick_d_reg && h_cnt_reg == 12'h000 && v_cnt_reg == 12'h000) begin
    frame_count_reg <= frame_count_reg + 8'h01;
  end
end

reg  [31:0] status_word;

always @* begin
  status_word = 32'h00000000;
  status_word[`STAT_LINE_MSB:0]              = v_cnt_reg;
  status_word[`STAT_VALID_BIT]               = pixel_valid;
  status_word[`STAT_VSYNC_BIT]               = en_reg & v_sync_on;
  status_word[`STAT_HSYNC_BIT]               = en_reg & h_sync_on;
  status_word[`STAT_FRM_MSB:`STAT_FRM_LSB]   = frame_count_reg;
end

always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_arready <= 1'b1;
    s_axi_rvalid  <= 1'b0;
    s_axi_rresp   <= `RESP_OKAY;
    s_axi_rdata   <= 32'h00000000;
  end else begin
    if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_axi_araddr)
        `OFF_CTRL:   s_axi_rdata <= ctrl_reg;
        `OFF_HSIZE:  s_axi_rdata <= hsize_reg;
        `OFF_HPORCH: s_axi_rdata <= hporch_reg;
        `OFF_VSIZE:  s_axi_rdata <= vsize_reg;
        `OFF_VPORCH: s_axi_rdata <= vporch_reg;
        `OFF_STATUS: s_axi_rdata <= status_word;
        default:     s_axi_rdata <= 32'h00000000;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
end

endmodule
`default_nettype wire

// ==== testbench/rgb_timing_checker.sv ====
// checker: sync, data-enable and pulse relations at the generator's ports
// assumes the bench timing of 4 active, 2 back, 2 front porch clocks and 20 aclk per pixel
`default_nettype none
module rgb_timing_checker #(
  parameter int ACT = 4,
  parameter int PIX = 20,
  parameter int GAP = 79,
  parameter int FRM = 959
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        pixel_take,
  input wire logic        line_sync,
  input wire logic        frame_sync,
  input wire logic        pixel_valid,
  input wire logic [23:0] rgb_out,
  input wire logic        frame_start
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] hi_cnt;
  logic [11:0] lo_cnt;
  logic [11:0] fs_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // cycles high, cycles low and cycles since the last frame start
  always @(posedge aclk) begin
    if (!aresetn) begin
      hi_cnt <= 12'h000;
      lo_cnt <= 12'hFFF;
      fs_cnt <= 12'hFFF;
    end else begin
      hi_cnt <= pixel_valid ? hi_cnt + 12'h001 : 12'h000;
      lo_cnt <= pixel_valid ? 12'h000 : ((lo_cnt == 12'hFFF) ? lo_cnt : lo_cnt + 12'h001);
      fs_cnt <= frame_start ? 12'h000 : ((fs_cnt == 12'hFFF) ? fs_cnt : fs_cnt + 12'h001);
    end
  end
  a_take_pulse: assert property (pixel_take |=> !pixel_take) else $error("pixel take longer than one cycle");
  a_start_pulse: assert property (frame_start |=> !frame_start) else $error("frame start not a pulse");
  a_start_blank: assert property (frame_start |-> !pixel_valid) else $error("valid at frame start");
  a_sync_pair: assert property ($changed(frame_sync) |-> $changed(line_sync))
    else $error("frame sync moved outside a line start");
  a_rgb_valid: assert property ($changed(rgb_out) |-> pixel_valid) else $error("pixel bus moved without valid");
  a_valid_width: assert property ($fell(pixel_valid) |-> hi_cnt >= ACT * PIX - 1 && hi_cnt <= ACT * PIX + 1)
    else $error("valid width wrong");
  a_porch_gap: assert property ($rose(pixel_valid) |-> lo_cnt >= GAP) else $error("porch gap too short");
  a_frame_len: assert property (frame_start |-> fs_cnt >= FRM) else $error("frame too short");
endmodule
bind rgb_timing_gen rgb_timing_checker rgb_timing_checker_i (
  .aclk(aclk), .aresetn(aresetn), .pixel_take(pixel_take), .line_sync(line_sync), .frame_sync(frame_sync),
  .pixel_valid(pixel_valid), .rgb_out(rgb_out), .frame_start(frame_start)
);
`default_nettype wire

// ==== testbench/lcd_panel_model.sv ====
// panel model: latches pixels under pixel_valid on the sampling edge of the pixel clock
// assumes cpol mirrors the generator's clock polarity bit
`default_nettype none
module lcd_panel_model (
  input  wire logic        pclk,
  input  wire logic        cpol,
  input  wire logic        valid,
  input  wire logic [23:0] rgb,
  output logic      [15:0] line_px,
  output logic      [15:0] lines,
  output logic      [23:0] last_px
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] cnt;
  initial begin
    cnt = 16'h0000;
    lines = 16'h0000;
    line_px = 16'h0000;
    last_px = 24'h000000;
  end
  // high polarity samples on rising edges, low on falling
  always @(posedge pclk or negedge pclk) begin
    if (pclk === cpol) begin
      if (valid === 1'b1) begin
        cnt <= cnt + 16'h0001;
        last_px <= rgb;
      end else if (cnt != 16'h0000) begin
        line_px <= cnt;
        lines <= lines + 16'h0001;
        cnt <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/rgb_timing_gen_tb_top.sv ====
// testbench: registers over axi4-lite, free pixel clock, frame timing judged from the ports
// assumes the generator, its map header, the panel model and the bound checker
`default_nettype none
`include "rgb_timing_map.vh"
module rgb_timing_gen_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PIX = 20;
  logic        aclk, aresetn, pclk_in, cpol;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [23:0] pixel_in;
  wire         awready, wready, bvalid, arready, rvalid, pixel_take, pclk_out;
  wire         line_sync, frame_sync, pixel_valid, frame_start;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [23:0] rgb_out, last_px;
  wire  [15:0] line_px, lines;
  int          fail_count, n_checks;
  int          cyc = 0;

  rgb_timing_gen rgb_timing_gen_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pixel_clock_in(pclk_in), .pixel_in(pixel_in), .pixel_take(pixel_take), .pixel_clock_out(pclk_out),
    .line_sync(line_sync), .frame_sync(frame_sync), .pixel_valid(pixel_valid), .rgb_out(rgb_out),
    .frame_start(frame_start)
  );
  lcd_panel_model lcd_panel_model_i (
    .pclk(pclk_out), .cpol(cpol), .valid(pixel_valid), .rgb(rgb_out), .line_px(line_px), .lines(lines),
    .last_px(last_px)
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    pclk_in = 1'b0;
    #7;
    forever #40 pclk_in = ~pclk_in;
  end
  always @(posedge aclk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chkr(input string nm, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, da, dw, tb;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      #1;
      ta = awready && !da;
      tw = wready && !dw;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end while (!(da && dw));
    bready <= 1'b1;
    do begin
      #1;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
    end while (!tb);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic tv;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      #1;
      tv = arready;
      @(posedge aclk);
    end while (!tv);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      #1;
      tv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end while (!tv);
    rready <= 1'b0;
  endtask
  task automatic wait_fs(output int t);
    do begin
      @(posedge aclk);
      #1;
    end while (frame_start !== 1'b1);
    t = cyc;
  endtask
  // one whole frame: length, sync and valid times, lines and pixels drawn
  task automatic frame_check(input logic ph, input logic pv, input int nl);
    int t0, l0, hs, vs, de;
    hs = 0;
    vs = 0;
    de = 0;
    wait_fs(t0);
    l0 = lines;
    for (int k = 0; k == 0 || frame_start !== 1'b1; k++) begin
      if (k == 3) chk("line sync level", ph, line_sync);
      if (k == 3) chk("frame sync level", pv, frame_sync);
      hs += (line_sync === ph);
      vs += (frame_sync === pv);
      de += (pixel_valid === 1'b1);
      @(posedge aclk);
      #1;
    end
    chkr("frame length", nl * 8 * PIX - 2, nl * 8 * PIX + 2, cyc - t0);
    chkr("line sync time", nl * PIX - 3, nl * PIX + 3, hs);
    chkr("frame sync time", 8 * PIX - 3, 8 * PIX + 3, vs);
    chkr("valid time", 12 * PIX - 3, 12 * PIX + 3, de);
    chk("active lines", 32'h3, lines - l0);
    chk("pixels per line", 32'h4, line_px);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0]  offs [5] = '{`OFF_CTRL, `OFF_HSIZE, `OFF_HPORCH, `OFF_VSIZE, `OFF_VPORCH};
    logic [31:0] rst [5] = '{32'h0, 32'h00010280, 32'h0072002E, 32'h000101E0, 32'h000B0022};
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 5; i++) begin
      axr(offs[i], d, r);
      chk("reset value", rst[i], d);
    end
    axw(`OFF_STATUS, 32'hFFFFFFFF, r);
    axr(`OFF_STATUS, d, r);
    chk("idle status", 32'h0, d);
    axr(8'h18, d, r);
    chk("unmapped rresp", `RESP_SLVERR, r);
    axw(8'h18, 32'hFFFFFFFF, r);
    chk("unmapped bresp", `RESP_SLVERR, r);
  endtask
  task automatic t_frames;
    logic [1:0] r;
    axw(`OFF_HSIZE, 32'h00010004, r);
    axw(`OFF_HPORCH, 32'h00020002, r);
    axw(`OFF_VSIZE, 32'h00010003, r);
    axw(`OFF_VPORCH, 32'h00010002, r);
    axw(`OFF_CTRL, 32'h00000001, r);
    chk("write resp", `RESP_OKAY, r);
    frame_check(1'b0, 1'b0, 6);
    frame_check(1'b0, 1'b0, 6);
  endtask
  task automatic t_pol;
    logic [1:0] r;
    int t;
    axw(`OFF_CTRL, 32'h00000007, r);
    wait_fs(t);
    frame_check(1'b1, 1'b1, 6);
  endtask
  task automatic t_depth;
    logic [23:0] px;
    logic [23:0] exp [3];
    logic [1:0]  r;
    int t;
    px = pixel_in;
    exp[0] = px;
    exp[1] = {6'h00, px[23:18], px[15:10], px[7:2]};
    exp[2] = {8'h00, px[23:19], px[15:10], px[7:3]};
    for (int d = 0; d < 3; d++) begin
      // stop at a frame end before the launch edge moves, then restart after a quiet frame
      axw(`OFF_CTRL, {26'h0, d[1:0], (d == 1), 3'h0}, r);
      wait_fs(t);
      cpol = (d == 1);
      repeat (48 * PIX) @(posedge aclk);
      axw(`OFF_CTRL, {26'h0, d[1:0], (d == 1), 3'h1}, r);
      wait_fs(t);
      frame_check(1'b0, 1'b0, 6);
      chk("drawn pixel", exp[d], last_px);
    end
  endtask
  task automatic t_mid;
    logic [1:0] r;
    int t0, t1;
    wait_fs(t0);
    repeat (200) @(posedge aclk);
    // blank split evenly: back porch 2 with a one-line active-low sync, front porch 2
    axw(`OFF_VPORCH, 32'h00020002, r);
    wait_fs(t1);
    chkr("frame during write", 48 * PIX - 2, 48 * PIX + 2, t1 - t0);
    frame_check(1'b0, 1'b0, 7);
  endtask
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    repeat (300) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    #1;
    chk("valid in reset", 32'h0, pixel_valid);
    chk("syncs in reset", 32'h3, {line_sync, frame_sync});
    @(posedge aclk);
    aresetn <= 1'b1;
    axr(`OFF_CTRL, d, r);
    chk("ctrl after reset", 32'h0, d);
    repeat (400) @(posedge aclk);
    chk("valid while stopped", 32'h0, pixel_valid);
  endtask
  task automatic test_done;
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    pixel_in = 24'hABCDEF;
    cpol = 1'b0;
    fail_count = 0;
    n_checks = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_frames();
    t_pol();
    t_depth();
    t_mid();
    t_reset();
    test_done();
  end
  initial begin
    #240000;
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
